// File: verilog/tmr_pkg.sv
// constants, offsets and field layout of the timer and watchdog block
// assumes a 100 MHz system clock and a 64-byte register window
package tmr_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned BASE_TICK_HZ = 2_000_000;
  localparam int unsigned BASE_DIV = CLK_HZ / BASE_TICK_HZ;

  localparam int unsigned SHORT_TIMER_W = 16;
  localparam int unsigned LONG_TIMER_W = 32;

  // register byte offsets inside the timer window
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_LATCH = 6'h04;
  localparam logic [5:0] OFS_WDOG = 6'h08;
  localparam logic [5:0] OFS_KEEP = 6'h0c;
  localparam logic [5:0] OFS_RLD12 = 6'h10;
  localparam logic [5:0] OFS_RLD3 = 6'h14;
  localparam logic [5:0] OFS_RLD4 = 6'h18;
  localparam logic [5:0] OFS_CNT12 = 6'h20;
  localparam logic [5:0] OFS_CNT3 = 6'h24;
  localparam logic [5:0] OFS_CNT4 = 6'h28;
  localparam logic [5:0] OFS_CLR1 = 6'h30;
  localparam logic [5:0] OFS_CLR2 = 6'h34;
  localparam logic [5:0] OFS_CLR3 = 6'h38;
  localparam logic [5:0] OFS_CLR4 = 6'h3c;

  // timer control: one byte lane per timer
  localparam int unsigned CTL_STRIDE = 8;
  localparam int unsigned CTL_CAUSE = 0;
  localparam int unsigned CTL_EN = 1;
  localparam int unsigned CTL_IRQEN = 2;
  localparam int unsigned CTL_CLK = 3;
  localparam int unsigned LATCH_ALL_BIT = 0;
  localparam int unsigned WD_EN_BIT = 0;
  localparam int unsigned WD_SEL_LSB = 8;
  localparam int unsigned WD_RESP_BIT = 16;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic LATCH_RST = 1'b0;
  localparam logic WD_EN_RST = 1'b0;
  localparam logic [2:0] WD_SEL_RST = 3'h0;
  localparam logic WD_RESP_RST = 1'b0;

  // watchdog timeouts in microseconds, index is the select code
  localparam logic [7:0][27:0] WDT_LIMIT_US = {
    28'd2_048, 28'd32_768, 28'd131_000, 28'd262_000,
    28'd524_000, 28'd2_100_000, 28'd33_600_000, 28'd135_000_000};

  localparam int unsigned SYSRST_PULSE_NS = 160;
  localparam int unsigned SYSRST_PULSE_CYC = SYSRST_PULSE_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    RATE_2M = 2'b00,
    RATE_1M = 2'b01,
    RATE_500K = 2'b10,
    RATE_250K = 2'b11
  } rate_e;

endpackage

// File: verilog/tmr_link_if.sv
// carrier between the timer core, its rate generator and the watchdog
// all members are single-clock signals on sys_clk
interface tmr_link_if;
  logic [3:0] tick;
  logic wd_en;
  logic [2:0] wd_sel;
  logic wd_kick;
  logic wd_expire;
  modport gen (output tick);
  modport dog (input tick, input wd_en, input wd_sel, input wd_kick,
               output wd_expire);
  modport core (input tick, output wd_en, output wd_sel, output wd_kick,
                input wd_expire);
endinterface

// File: verilog/tmr_rate_gen.sv
// timer clock generator: one-cycle ticks at 2 MHz, 1 MHz, 500 kHz, 250 kHz
// assumes sys_clk divided by DIV gives the 2 MHz base rate
module tmr_rate_gen #(
  parameter int unsigned DIV = tmr_pkg::BASE_DIV
) (
  input wire logic sys_clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic ce, // clock enable, freezes state
  tmr_link_if.gen lnk // tick outputs
);
  import tmr_pkg::*;

  localparam int unsigned CW = $clog2(DIV);
  localparam logic [3:0][2:0] PRE_MASK = {3'h7, 3'h3, 3'h1, 3'h0};

  if (DIV < 2) begin : g_bad_div
    $error("tmr_rate_gen: DIV must be at least 2");
  end

  typedef struct packed {
    logic [CW-1:0] div;
    logic [2:0] pre;
    logic [3:0] tick;
  } state_s;

  state_s st_q;
  state_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.tick = 4'h0;
    st_d.div = st_q.div + CW'(1);
    if (st_q.div == CW'(DIV - 1)) begin
      st_d.div = '0;
      st_d.pre = st_q.pre + 3'd1;
      // slower rates are every 2nd, 4th, 8th base tick
      for (int k = 0; k < 4; k++) begin
        st_d.tick[k] = (st_q.pre & PRE_MASK[k]) == PRE_MASK[k];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign lnk.tick = st_q.tick;

endmodule // tmr_rate_gen

// File: verilog/tmr_watchdog.sv
// watchdog counter, counts 1 MHz ticks down from the selected timeout
// assumes enable, select and keepalive pulse come from the register core
module tmr_watchdog #(
  parameter logic [7:0][27:0] LIMIT_US = tmr_pkg::WDT_LIMIT_US
) (
  input wire logic sys_clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic ce, // clock enable, freezes state
  tmr_link_if.dog lnk // control in, expiry pulse out
);
  import tmr_pkg::*;

  typedef struct packed {
    logic en_seen;
    logic [27:0] left;
    logic expire;
  } state_s;

  state_s st_q;
  state_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.expire = 1'b0;
    st_d.en_seen = lnk.wd_en;
    if (!lnk.wd_en) begin
      st_d.left = st_q.left;
    end else if (!st_q.en_seen || lnk.wd_kick) begin
      // new select code only takes effect at a restart or at the reload after an expiry
      st_d.left = LIMIT_US[lnk.wd_sel];
    end else if (lnk.tick[RATE_1M]) begin
      if (st_q.left <= 28'd1) begin
        st_d.expire = 1'b1;
        st_d.left = LIMIT_US[lnk.wd_sel];
      end else begin
        st_d.left = st_q.left - 28'd1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign lnk.wd_expire = st_q.expire;

endmodule // tmr_watchdog

// File: verilog/pci_timers_and_watchdog.sv
// four down-counting timers and a watchdog behind a 64-byte memory window
// assumes the bridge presents single-cycle word accesses with byte enables
//
// Behaviour
// - terminal count sets the timer's cause flag
// - writing zero to cause flag clears it
// - latch mode select in bit zero
// - mode zero: each count read latches
// - mode one: pair read latches all four
// - sixteen-bit reload pair, word or halfword
// - thirty-two-bit reloads for timers three, four
// - reload write loads on next tick
// - terminal count reloads and keeps counting
// - count registers return latched counts
// - any write to clear register clears
// - watchdog enable, timeout select, response select
// - eight timeouts from 135s to 2.048ms
// - expiry gives reset or SERR
// - keepalive write restarts the watchdog
// - clock select picks 2M/1M/500k/250k
// - enable starts timer, irq enable gates
module pci_timers_and_watchdog #(
  parameter int unsigned SHORT_W = tmr_pkg::SHORT_TIMER_W,
  parameter int unsigned LONG_W = tmr_pkg::LONG_TIMER_W,
  parameter int unsigned BASE_DIV = tmr_pkg::BASE_DIV,
  parameter logic [7:0][27:0] WDT_LIMIT_US = tmr_pkg::WDT_LIMIT_US,
  parameter int unsigned RST_PULSE_CYC = tmr_pkg::SYSRST_PULSE_CYC
) (
  input wire logic sys_clk, // system clock, 100 MHz
  input wire logic arst_n, // async reset, active low
  input wire logic ce, // clock enable, freezes state
  input wire logic [5:0] reg_addr, // byte offset in window
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic reg_rd, // read strobe, one cycle
  input wire logic [3:0] reg_be, // byte enables
  input wire logic [31:0] reg_wdata, // write data
  output logic [31:0] reg_rdata, // read data
  output logic reg_rvalid, // read data valid pulse
  output logic timer_irq, // shared timer interrupt
  output logic sys_reset_req, // watchdog system reset
  output logic serr_out, // error line level, always low
  output logic serr_oe // error line drive enable
);
  import tmr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // parameter checks and width masks

  if (SHORT_W < 1 || SHORT_W > 16) begin : g_bad_short
    $error("pci_timers_and_watchdog: SHORT_W must be 1..16");
  end
  if (LONG_W < SHORT_W || LONG_W > 32) begin : g_bad_long
    $error("pci_timers_and_watchdog: LONG_W must be SHORT_W..32");
  end
  if (RST_PULSE_CYC < 1 || RST_PULSE_CYC > 255) begin : g_bad_rst
    $error("pci_timers_and_watchdog: RST_PULSE_CYC must be 1..255");
  end

  localparam logic [32:0] SHORT_ONE = 33'h1 << SHORT_W;
  localparam logic [32:0] LONG_ONE = 33'h1 << LONG_W;
  localparam logic [31:0] SHORT_MASK = 32'(SHORT_ONE - 33'h1);
  localparam logic [31:0] LONG_MASK = 32'(LONG_ONE - 33'h1);
  localparam logic [7:0] RST_LOAD = 8'(RST_PULSE_CYC);

  // timers 1 and 2 are the short ones
  function automatic logic [31:0] wmask(input int idx);
    return (idx < 2) ? SHORT_MASK : LONG_MASK;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [31:0] ctrl;
    logic latch_all;
    logic wd_en;
    logic [2:0] wd_sel;
    logic wd_resp;
    logic wd_kick;
    logic [3:0][31:0] reload;
    logic [3:0][31:0] count;
    logic [3:0] load_pend;
    logic [3:0][31:0] snap;
    logic [31:0] rdata;
    logic rvalid;
    logic irq;
    logic [7:0] rst_cnt;
    logic rst_req;
    logic serr_out;
    logic serr_oe;
  } state_s;

  state_s st_q;
  state_s st_d;

  tmr_link_if lnk ();

  tmr_rate_gen #(
    .DIV(BASE_DIV)
  ) u_rate (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .ce(ce),
    .lnk(lnk)
  );

  tmr_watchdog #(
    .LIMIT_US(WDT_LIMIT_US)
  ) u_dog (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .ce(ce),
    .lnk(lnk)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [3:0] hit;
    logic [31:0] tmp;
    logic [1:0] sel;
    hit = 4'h0;
    tmp = 32'h0;
    sel = 2'b00;
    st_d = st_q;
    st_d.rvalid = 1'b0;
    st_d.wd_kick = 1'b0;
    st_d.serr_oe = 1'b0;

    // counting, one tick of the selected rate per step
    for (int i = 0; i < 4; i++) begin
      sel = st_q.ctrl[i*CTL_STRIDE + CTL_CLK +: 2];
      if (lnk.tick[sel]) begin
        if (st_q.load_pend[i]) begin
          // load happens even while the timer is disabled
          st_d.count[i] = st_q.reload[i];
          st_d.load_pend[i] = 1'b0;
        end else if (st_q.ctrl[i*CTL_STRIDE + CTL_EN]) begin
          if (st_q.count[i] == 32'h0) begin
            st_d.count[i] = st_q.reload[i];
            hit[i] = 1'b1;
          end else begin
            st_d.count[i] = (st_q.count[i] - 32'h1) & wmask(i);
          end
        end
      end
    end

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL: begin
          st_d.ctrl = merge(st_q.ctrl, reg_wdata, reg_be);
          for (int i = 0; i < 4; i++) begin
            // a one leaves the flag alone, a zero clears it
            st_d.ctrl[i*CTL_STRIDE + CTL_CAUSE] =
              st_q.ctrl[i*CTL_STRIDE + CTL_CAUSE] &
              (reg_wdata[i*CTL_STRIDE + CTL_CAUSE] | ~reg_be[i]);
          end
        end
        OFS_LATCH: begin
          if (reg_be[0]) begin
            st_d.latch_all = reg_wdata[LATCH_ALL_BIT];
          end
        end
        OFS_WDOG: begin
          if (reg_be[0]) begin
            st_d.wd_en = reg_wdata[WD_EN_BIT];
          end
          if (reg_be[1]) begin
            st_d.wd_sel = reg_wdata[WD_SEL_LSB +: 3];
          end
          if (reg_be[2]) begin
            st_d.wd_resp = reg_wdata[WD_RESP_BIT];
          end
        end
        OFS_KEEP: begin
          st_d.wd_kick = 1'b1;
        end
        OFS_RLD12: begin
          tmp = merge({st_q.reload[1][15:0], st_q.reload[0][15:0]},
                      reg_wdata, reg_be);
          st_d.reload[0] = {16'h0, tmp[15:0]} & wmask(0);
          st_d.reload[1] = {16'h0, tmp[31:16]} & wmask(1);
          if (|reg_be[1:0]) begin
            st_d.load_pend[0] = 1'b1;
          end
          if (|reg_be[3:2]) begin
            st_d.load_pend[1] = 1'b1;
          end
        end
        OFS_RLD3: begin
          st_d.reload[2] = merge(st_q.reload[2], reg_wdata, reg_be)
                           & wmask(2);
          st_d.load_pend[2] = st_d.load_pend[2] | (|reg_be);
        end
        OFS_RLD4: begin
          st_d.reload[3] = merge(st_q.reload[3], reg_wdata, reg_be)
                           & wmask(3);
          st_d.load_pend[3] = st_d.load_pend[3] | (|reg_be);
        end
        OFS_CLR1: st_d.ctrl[0*CTL_STRIDE + CTL_CAUSE] = 1'b0;
        OFS_CLR2: st_d.ctrl[1*CTL_STRIDE + CTL_CAUSE] = 1'b0;
        OFS_CLR3: st_d.ctrl[2*CTL_STRIDE + CTL_CAUSE] = 1'b0;
        OFS_CLR4: st_d.ctrl[3*CTL_STRIDE + CTL_CAUSE] = 1'b0;
        default: ;
      endcase
    end

    // a terminal count in the clearing cycle must not be lost
    for (int i = 0; i < 4; i++) begin
      if (hit[i]) begin
        st_d.ctrl[i*CTL_STRIDE + CTL_CAUSE] = 1'b1;
      end
    end

    // register reads, answered one cycle later
    if (reg_rd) begin
      st_d.rvalid = 1'b1;
      st_d.rdata = 32'h0;
      case (reg_addr)
        OFS_CTRL: st_d.rdata = st_q.ctrl;
        OFS_LATCH: st_d.rdata = {31'h0, st_q.latch_all};
        OFS_WDOG: begin
          st_d.rdata[WD_EN_BIT] = st_q.wd_en;
          st_d.rdata[WD_SEL_LSB +: 3] = st_q.wd_sel;
          st_d.rdata[WD_RESP_BIT] = st_q.wd_resp;
        end
        OFS_RLD12: st_d.rdata = {st_q.reload[1][15:0],
                                 st_q.reload[0][15:0]};
        OFS_RLD3: st_d.rdata = st_q.reload[2];
        OFS_RLD4: st_d.rdata = st_q.reload[3];
        OFS_CNT12: begin
          st_d.snap[0] = st_q.count[0];
          st_d.snap[1] = st_q.count[1];
          if (st_q.latch_all) begin
            st_d.snap[2] = st_q.count[2];
            st_d.snap[3] = st_q.count[3];
          end
          st_d.rdata = {st_d.snap[1][15:0], st_d.snap[0][15:0]};
        end
        OFS_CNT3: begin
          if (!st_q.latch_all) begin
            st_d.snap[2] = st_q.count[2];
          end
          st_d.rdata = st_d.snap[2];
        end
        OFS_CNT4: begin
          if (!st_q.latch_all) begin
            st_d.snap[3] = st_q.count[3];
          end
          st_d.rdata = st_d.snap[3];
        end
        default: st_d.rdata = 32'h0;
      endcase
    end

    // shared interrupt, gated per timer
    st_d.irq = 1'b0;
    for (int i = 0; i < 4; i++) begin
      st_d.irq = st_d.irq | (st_d.ctrl[i*CTL_STRIDE + CTL_CAUSE] &
                             st_d.ctrl[i*CTL_STRIDE + CTL_IRQEN]);
    end

    // watchdog response
    if (st_q.rst_cnt != 8'h0) begin
      st_d.rst_cnt = st_q.rst_cnt - 8'h1;
    end
    if (lnk.wd_expire) begin
      if (st_q.wd_resp) begin
        st_d.serr_oe = 1'b1;
      end else begin
        st_d.rst_cnt = RST_LOAD;
      end
    end
    st_d.rst_req = st_d.rst_cnt != 8'h0;
    st_d.serr_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
      st_q.ctrl <= CTRL_RST;
      st_q.latch_all <= LATCH_RST;
      st_q.wd_en <= WD_EN_RST;
      st_q.wd_sel <= WD_SEL_RST;
      st_q.wd_resp <= WD_RESP_RST;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign lnk.wd_en = st_q.wd_en;
  assign lnk.wd_sel = st_q.wd_sel;
  assign lnk.wd_kick = st_q.wd_kick;

  assign reg_rdata = st_q.rdata;
  assign reg_rvalid = st_q.rvalid;
  assign timer_irq = st_q.irq;
  assign sys_reset_req = st_q.rst_req;
  assign serr_out = st_q.serr_out;
  assign serr_oe = st_q.serr_oe;

endmodule // pci_timers_and_watchdog

// File: bench/tmr_props.sv
// checker for the timer and watchdog block
// sees only the top ports; bound at the foot of this file
module tmr_props #(
  parameter int unsigned RST_PULSE_CYC = 16
) (
  input wire logic sys_clk, // clock
  input wire logic arst_n, // reset
  input wire logic ce, // enable
  input wire logic [5:0] reg_addr, // offset
  input wire logic reg_wr, // write
  input wire logic reg_rd, // read
  input wire logic [3:0] reg_be, // lanes
  input wire logic [31:0] reg_wdata, // data in
  input wire logic [31:0] reg_rdata, // data out
  input wire logic reg_rvalid, // answer
  input wire logic timer_irq, // irq
  input wire logic sys_reset_req, // reset request
  input wire logic serr_out, // error level
  input wire logic serr_oe // error enable
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] wide_q; // reset pulse length so far
  logic en_q; // shadow of watchdog enable
  logic resp_q; // shadow of response select
  logic [2:0] off_q; // cycles since disable, saturating
  logic wd_wr;
  assign wd_wr = ce && reg_wr && reg_addr == 6'h08;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wide_q <= 8'h00;
      en_q <= 1'b0;
      resp_q <= 1'b0;
      off_q <= 3'h0;
    end else begin
      wide_q <= sys_reset_req ? wide_q + 8'h01 : 8'h00;
      if (wd_wr && reg_be[0]) en_q <= reg_wdata[0];
      if (wd_wr && reg_be[2]) resp_q <= reg_wdata[16];
      if (en_q) off_q <= 3'h0;
      else if (off_q != 3'h7) off_q <= off_q + 3'h1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_read_answer: assert property (ce && reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_no_stray: assert property (!(ce && reg_rd) |=> !reg_rvalid)
    else $error("answer without read");
  a_rdata_holds: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved");
  a_clear_reads_zero: assert property (ce && reg_rd &&
    (reg_addr >= 6'h30 || reg_addr == 6'h0c) |=> reg_rdata == 32'h0)
    else $error("write-only place read nonzero");
  a_serr_one_cycle: assert property (serr_oe |=> !serr_oe)
    else $error("error enable too long");
  a_serr_level_low: assert property (serr_out == 1'b0)
    else $error("error level not low");
  a_reset_width: assert property ($fell(sys_reset_req) |->
    wide_q == 8'(RST_PULSE_CYC)) else $error("reset pulse width");
  a_reset_resp_zero: assert property ($rose(sys_reset_req) |-> !resp_q)
    else $error("reset with error response chosen");
  a_serr_resp_one: assert property ($rose(serr_oe) |-> resp_q)
    else $error("error with reset response chosen");
  a_quiet_when_off: assert property (off_q == 3'h7 |->
    !$rose(sys_reset_req) && !$rose(serr_oe)) else $error("expiry while off");
  c_read: cover property (reg_rvalid);
  c_irq: cover property ($rose(timer_irq));
  c_serr: cover property (serr_oe);
  c_reset: cover property ($fell(sys_reset_req));
endmodule // tmr_props

bind pci_timers_and_watchdog tmr_props #(
  .RST_PULSE_CYC(RST_PULSE_CYC)
) chk (.sys_clk(sys_clk), .arst_n(arst_n), .ce(ce), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .timer_irq(timer_irq),
  .sys_reset_req(sys_reset_req), .serr_out(serr_out), .serr_oe(serr_oe));

// File: bench/tmr_host.sv
// host processor model issuing register accesses
// assumes single-cycle strobes taken on sys_clk
module tmr_host (
  input wire logic sys_clk, // clock
  output logic [5:0] reg_addr, // offset
  output logic reg_wr, // write strobe
  output logic reg_rd, // read strobe
  output logic [3:0] reg_be, // lanes
  output logic [31:0] reg_wdata, // data
  input wire logic [31:0] reg_rdata, // read data
  input wire logic reg_rvalid // answer
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_addr = 6'h3f;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_be = 4'h0;
    reg_wdata = 32'h0;
  end
  // idle lines show the inverse so stale values never look valid
  task automatic wr(input logic [5:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_be <= be;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    d = 'x;
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge sys_clk);
    if (reg_rvalid === 1'b1) d = reg_rdata;
  endtask
  task automatic causes(output logic [3:0] c);
    logic [31:0] v;
    rd(6'h00, v);
    c = {v[24], v[16], v[8], v[0]};
  endtask
  task automatic clr_cause(input int i);
    logic [31:0] v;
    rd(6'h00, v);
    v[8*i] = 1'b0;
    wr(6'h00, 4'(1 << i), v);
  endtask
  task automatic snap(output logic [31:0] p12, p3, p4);
    wr(6'h04, 4'h1, 32'h1);
    rd(6'h20, p12);
    rd(6'h24, p3);
    rd(6'h28, p4);
  endtask
endmodule // tmr_host

// File: bench/pci_timers_and_watchdog_test.sv
// self-checking bench for the timer and watchdog block
// assumes shortened base divider and watchdog limits
module pci_timers_and_watchdog_test;
  timeunit 1ns;
  timeprecision 100ps;
  import tmr_pkg::*;
  localparam int BD = 2;
  localparam int RPC = 16;
  // limit for code c is 24-3c microsecond ticks
  localparam logic [7:0][27:0] LIM = {28'd3, 28'd6, 28'd9, 28'd12,
    28'd15, 28'd18, 28'd21, 28'd24};
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic [5:0] reg_addr;
  logic reg_wr, reg_rd, reg_rvalid, timer_irq, sys_reset_req;
  logic serr_out, serr_oe;
  logic [3:0] reg_be;
  logic [31:0] reg_wdata, reg_rdata;
  int bad_count, comparisons, cyc, t0;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  pci_timers_and_watchdog #(.BASE_DIV(BD), .WDT_LIMIT_US(LIM),
    .RST_PULSE_CYC(RPC)) dut (.sys_clk(sys_clk), .arst_n(arst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_be(reg_be),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .timer_irq(timer_irq), .sys_reset_req(sys_reset_req),
    .serr_out(serr_out), .serr_oe(serr_oe));
  tmr_host host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  //////////////////////////////////////////////////////////////////////
  task automatic results;
    if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic rdc(input string w, input logic [5:0] a,
                     input logic [31:0] e);
    logic [31:0] d;
    host.rd(a, d);
    chk(w, e, d);
  endtask
  task automatic wait_sig(input int s, input logic lv);
    logic v;
    for (int n = 0; n < 4000; n++) begin
      @(negedge sys_clk);
      v = s == 0 ? timer_irq : s == 1 ? serr_oe : sys_reset_req;
      if (v === lv) return;
    end
    bad_count++;
    results();
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc("ctrl", OFS_CTRL, CTRL_RST);
    rdc("latch", OFS_LATCH, 32'h0);
    rdc("wdog", OFS_WDOG, 32'h0);
    rdc("keep", OFS_KEEP, 32'h0);
    rdc("clr4", OFS_CLR4, 32'h0);
    rdc("hole", 6'h2c, 32'h0);
  endtask
  task automatic t_reload;
    host.wr(OFS_RLD12, 4'h3, 32'h5555_1234);
    repeat (20) @(posedge sys_clk);
    rdc("cnt12 low", OFS_CNT12, 32'h0000_1234);
    host.wr(OFS_RLD12, 4'hc, 32'habcd_0000);
    host.wr(OFS_RLD3, 4'hf, 32'hffff_fffe);
    host.wr(OFS_RLD4, 4'hf, 32'h8000_0001);
    host.wr(OFS_CNT3, 4'hf, 32'h0);
    repeat (20) @(posedge sys_clk);
    rdc("rld12", OFS_RLD12, 32'habcd_1234);
    rdc("cnt12", OFS_CNT12, 32'habcd_1234);
    rdc("cnt3", OFS_CNT3, 32'hffff_fffe);
    rdc("cnt4", OFS_CNT4, 32'h8000_0001);
  endtask
  task automatic t_cause;
    logic [3:0] c;
    host.wr(OFS_RLD12, 4'hf, 32'h0005_0005);
    host.wr(OFS_CTRL, 4'h3, 32'h0000_0202);
    repeat (30) @(negedge sys_clk);
    chk("irq masked", 1'b0, timer_irq);
    host.wr(OFS_CTRL, 4'h3, 32'h0000_0101);
    host.causes(c);
    chk("both causes", 4'h3, c);
    host.clr_cause(0);
    host.causes(c);
    chk("one cleared", 4'h2, c);
    host.wr(OFS_CTRL, 4'h2, 32'h0000_0500);
    repeat (2) @(negedge sys_clk);
    chk("irq on", 1'b1, timer_irq);
    host.wr(OFS_CLR2, 4'h0, 32'h0);
    repeat (2) @(negedge sys_clk);
    chk("irq off", 1'b0, timer_irq);
    host.causes(c);
    chk("no causes", 4'h0, c);
    // the other clear registers, data and lanes ignored
    host.wr(OFS_RLD3, 4'hf, 32'h5);
    host.wr(OFS_CTRL, 4'h7, 32'h0002_0202);
    repeat (30) @(posedge sys_clk);
    host.wr(OFS_CTRL, 4'h7, 32'h0001_0101);
    host.wr(OFS_CLR1, 4'h0, 32'h0);
    host.wr(OFS_CLR3, 4'hf, 32'hffff_ffff);
    host.causes(c);
    chk("clr1 clr3", 4'h2, c);
  endtask
  task automatic t_rates;
    for (int r = 0; r < 4; r++) begin
      host.wr(OFS_RLD4, 4'hf, 32'h3);
      host.wr(OFS_CTRL, 4'h8, {5'(r << 3) | 8'h06, 24'h0});
      wait_sig(0, 1'b1);
      t0 = cyc;
      host.wr(OFS_CLR4, 4'hf, 32'hffff_ffff);
      wait_sig(0, 1'b0);
      wait_sig(0, 1'b1);
      chk("period", 32'(4 * BD * (1 << r)), 32'(cyc - t0));
      host.wr(OFS_CTRL, 4'h8, 32'h0);
      host.wr(OFS_CLR4, 4'hf, 32'h0);
    end
  endtask
  task automatic t_latch;
    logic [31:0] a, b, p12, p3, p4;
    host.wr(OFS_RLD3, 4'hf, 32'hffff);
    host.wr(OFS_RLD4, 4'hf, 32'hffff);
    host.wr(OFS_CTRL, 4'hc, 32'h0202_0000);
    host.rd(OFS_CNT3, a);
    host.rd(OFS_CNT3, b);
    chk("relatch", 1'b1, a != b);
    // ce low must hold divider and count alike
    @(posedge sys_clk);
    ce <= 1'b0;
    repeat (20) @(posedge sys_clk);
    ce <= 1'b1;
    host.rd(OFS_CNT3, a);
    chk("frozen", 1'b1, b != a && b - a <= 32'h2);
    host.snap(p12, p3, p4);
    rdc("mode", OFS_LATCH, 32'h1);
    chk("coherent", p3, p4);
    repeat (10) @(posedge sys_clk);
    rdc("held3", OFS_CNT3, p3);
    rdc("held4", OFS_CNT4, p4);
    host.rd(OFS_CNT12, a);
    host.rd(OFS_CNT3, b);
    chk("new snap", 1'b1, b != p3);
    host.wr(OFS_LATCH, 4'hf, 32'h0);
    host.wr(OFS_CTRL, 4'hc, 32'h0);
  endtask
  task automatic t_wdog;
    for (int c = 0; c < 8; c++) begin
      host.wr(OFS_WDOG, 4'hf, 32'h0001_0001 | (c << 8));
      wait_sig(1, 1'b1);
      t0 = cyc;
      wait_sig(1, 1'b0);
      wait_sig(1, 1'b1);
      chk("wd period", 32'(LIM[c] * 2 * BD), 32'(cyc - t0));
      host.wr(OFS_WDOG, 4'hf, 32'h0);
    end
    host.wr(OFS_WDOG, 4'hf, 32'h0000_0001);
    for (int k = 0; k < 200; k++) begin
      if (k % 8 == 7) host.wr(OFS_KEEP, 4'hf, 32'h0);
      @(negedge sys_clk);
      chk("kept alive", 1'b0, sys_reset_req);
    end
    wait_sig(2, 1'b1);
    t0 = cyc;
    wait_sig(2, 1'b0);
    chk("rst width", 32'(RPC), 32'(cyc - t0));
    host.wr(OFS_WDOG, 4'h1, 32'h0);
    repeat (300) begin
      @(negedge sys_clk);
      chk("off quiet", 1'b0, sys_reset_req);
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset();
    t_reload();
    t_cause();
    t_rates();
    t_latch();
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset();
    t_wdog();
    results();
  end
endmodule // pci_timers_and_watchdog_test
